// >>> hw/crif_top.sv
`timescale 1ns/1ps
module crif_top (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [crif_pkg::CRIF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [crif_pkg::CRIF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          rc32_ready,
    input  wire logic                          slow_crystal_ready,
    input  wire logic                          rc16_ready,
    input  wire logic                          fast_crystal_ready,
    input  wire logic                          digital_pll_ready,
    input  wire logic                          crystal_stuck_detect,
    output logic                               clock_irq
);
    import crif_pkg::*;

    typedef struct packed {
        logic                   aw_have;
        logic [CRIF_ADDR_W-1:0] aw_addr;
        logic                   w_have;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [CRIF_NEN-1:0]    enable;
        logic [7:0]             mask;
        logic                   irq;
    } crif_state_type;

    crif_state_type         st_r;
    crif_state_type         st_nxt;
    logic [CRIF_NSRC-1:0]   ready_vec;
    logic [CRIF_NSRC-1:0]   enable_vec;
    logic [CRIF_NSRC-1:0]   clear_vec;
    logic [CRIF_NSRC-1:0]   flag_vec;
    logic [CRIF_NSRC-1:0]   mask_vec;
    logic [31:0]            ctrl_view;
    logic [CRIF_ADDR_W-1:0] w_word;
    logic [CRIF_ADDR_W-1:0] r_word;
    logic                   do_write;

    assign ready_vec = {crystal_stuck_detect, digital_pll_ready,
                        fast_crystal_ready, rc16_ready,
                        slow_crystal_ready, rc32_ready};
    // stuck flag always armed
    // Stuck flag has no enable of its own
    assign enable_vec = {1'b1, st_r.enable};

    // ------------------------------------------------------------
    // Flag cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < CRIF_NSRC; i++) begin : g_src
        assign mask_vec[i] = st_r.mask[CRIF_FLAG_POS[i]];
        crif_flag_cell u_cell (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ready   (ready_vec[i]),
            .enable  (enable_vec[i]),
            .clear   (clear_vec[i]),
            .flag    (flag_vec[i])
        );
    end

    // ------------------------------------------------------------
    // Register view and write decode
    // ------------------------------------------------------------
    assign w_word   = {st_r.aw_addr[CRIF_ADDR_W-1:2], 2'b00};
    assign r_word   = {s_axi_araddr[CRIF_ADDR_W-1:2], 2'b00};
    assign do_write = st_r.aw_have & st_r.w_have & ~st_r.bvalid;

    always_comb begin
        ctrl_view = CRIF_RST_INT_CTRL;
        clear_vec = '0;
        for (int i = 0; i < CRIF_NSRC; i++) begin
            ctrl_view[CRIF_FLAG_POS[i]] = flag_vec[i];
            clear_vec[i] = do_write && (w_word == CRIF_OFF_INT_CTRL)
                && st_r.w_strb[CRIF_CLEAR_POS[i] / CRIF_LANE_W]
                && st_r.w_data[CRIF_CLEAR_POS[i]];
        end
        for (int i = 0; i < CRIF_NEN; i++) begin
            ctrl_view[CRIF_ENABLE_POS[i]] = st_r.enable[i];
        end
    end

    // ------------------------------------------------------------
    // Bus slave and control state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = CRIF_RESP_OKAY;
            // flag bits have no write path
            if (w_word == CRIF_OFF_INT_CTRL) begin
                for (int i = 0; i < CRIF_NEN; i++) begin
                    if (st_r.w_strb[CRIF_ENABLE_POS[i] / CRIF_LANE_W]) begin
                        st_nxt.enable[i] =
                            st_r.w_data[CRIF_ENABLE_POS[i]];
                    end
                end
            end else if (w_word == CRIF_OFF_IRQ_MASK) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.mask = st_r.w_data[7:0];
                end
            end else begin
                st_nxt.bresp = CRIF_RESP_SLVERR;
            end
        end
        st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
        st_nxt.wready  = ~st_nxt.w_have & ~st_nxt.bvalid;

        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = CRIF_RESP_OKAY;
            st_nxt.rdata  = '0;
            if (r_word == CRIF_OFF_INT_CTRL) begin
                st_nxt.rdata = ctrl_view;
            end else if (r_word == CRIF_OFF_IRQ_MASK) begin
                st_nxt.rdata = {24'h00_0000, st_r.mask};
            end else begin
                st_nxt.rresp = CRIF_RESP_SLVERR;
            end
        end
        st_nxt.arready = ~st_nxt.rvalid;
        st_nxt.irq = |(flag_vec & mask_vec);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.enable  <= CRIF_RST_ENABLE;
            st_r.mask    <= CRIF_RST_IRQ_MASK;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign clock_irq     = st_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_stuck_set: assert property (
        $rose(crystal_stuck_detect) |=> flag_vec[5])
        else $error("stuck flag not set");
    chk_stuck_clear: assert property (
        clear_vec[5] && !$rose(crystal_stuck_detect) |=> !flag_vec[5])
        else $error("stuck flag not cleared");
    chk_pll_gate: assert property (
        !flag_vec[4] && !st_r.enable[4] |=> !flag_vec[4])
        else $error("pll flag set while disabled");
    chk_pll_clear: assert property (
        clear_vec[4] && !$rose(digital_pll_ready) |=> !flag_vec[4])
        else $error("pll flag not cleared");
    chk_fast_set: assert property (
        $rose(fast_crystal_ready) && st_r.enable[3] |=> flag_vec[3])
        else $error("fast crystal flag not set");
    chk_fast_clear: assert property (
        clear_vec[3] && !$rose(fast_crystal_ready) |=> !flag_vec[3])
        else $error("fast crystal flag not cleared");
    chk_rc16_set: assert property (
        $rose(rc16_ready) && st_r.enable[2] |=> flag_vec[2])
        else $error("rc16 flag not set");
    chk_flag_hold: assert property (
        flag_vec[2] && !clear_vec[2] |=> flag_vec[2])
        else $error("rc16 flag lost without clear");
    chk_slow_set: assert property (
        $rose(slow_crystal_ready) && st_r.enable[1] |=> flag_vec[1])
        else $error("slow crystal flag not set");
    chk_rc32_set: assert property (
        $rose(rc32_ready) && st_r.enable[0] |=> flag_vec[0])
        else $error("rc32 flag not set");
    chk_irq_level: assert property (
        |(flag_vec & mask_vec) |=> clock_irq)
        else $error("interrupt not raised");
    chk_set_wins: assert property (
        clear_vec[0] && $rose(rc32_ready) && st_r.enable[0] |=> flag_vec[0])
        else $error("set lost to clear");
    chk_write_resp: assert property (
        do_write |=> s_axi_bvalid)
        else $error("write answer missing");

    // ------------------------------------------------------------
    // Further flag and bus checks
    // ------------------------------------------------------------
    chk_pll_set: assert property (
        $rose(digital_pll_ready) && st_r.enable[4] |=> flag_vec[4])
        else $error("pll flag not set");
    chk_rc16_clear: assert property (
        clear_vec[2] && !$rose(rc16_ready) |=> !flag_vec[2])
        else $error("rc16 flag not cleared");
    chk_slow_clear: assert property (
        clear_vec[1] && !$rose(slow_crystal_ready) |=> !flag_vec[1])
        else $error("slow crystal flag not cleared");
    chk_rc32_clear: assert property (
        clear_vec[0] && !$rose(rc32_ready) |=> !flag_vec[0])
        else $error("rc32 flag not cleared");
    chk_fast_gate: assert property (
        !flag_vec[3] && !st_r.enable[3] |=> !flag_vec[3])
        else $error("fast crystal flag set while disabled");
    chk_rc16_gate: assert property (
        !flag_vec[2] && !st_r.enable[2] |=> !flag_vec[2])
        else $error("rc16 flag set while disabled");
    chk_slow_gate: assert property (
        !flag_vec[1] && !st_r.enable[1] |=> !flag_vec[1])
        else $error("slow crystal flag set while disabled");
    chk_rc32_gate: assert property (
        !flag_vec[0] && !st_r.enable[0] |=> !flag_vec[0])
        else $error("rc32 flag set while disabled");
    chk_stuck_hold: assert property (
        flag_vec[5] && !clear_vec[5] |=> flag_vec[5])
        else $error("stuck flag lost without clear");
    chk_pll_hold: assert property (
        flag_vec[4] && !clear_vec[4] |=> flag_vec[4])
        else $error("pll flag lost without clear");
    chk_fast_hold: assert property (
        flag_vec[3] && !clear_vec[3] |=> flag_vec[3])
        else $error("fast crystal flag lost without clear");
    chk_slow_hold: assert property (
        flag_vec[1] && !clear_vec[1] |=> flag_vec[1])
        else $error("slow crystal flag lost without clear");
    chk_rc32_hold: assert property (
        flag_vec[0] && !clear_vec[0] |=> flag_vec[0])
        else $error("rc32 flag lost without clear");
    chk_irq_low: assert property (
        !(|(flag_vec & mask_vec)) |=> !clock_irq)
        else $error("interrupt raised without flag");
    chk_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");

    cov_stuck_irq: cover property (flag_vec[5] ##1 clock_irq);
    cov_clear_write: cover property (|clear_vec);
    cov_read_ctrl: cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
    cov_set_clear: cover property (clear_vec[0] && $rose(rc32_ready));

endmodule : crif_top

// >>> hw/crif_pkg.sv
package crif_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned CRIF_ADDR_W       = 8;
    localparam int unsigned CRIF_DATA_W       = 32;
    localparam logic [7:0]  CRIF_OFF_INT_CTRL = 8'h0c;
    localparam logic [7:0]  CRIF_OFF_IRQ_MASK = 8'h40;
    localparam logic [31:0] CRIF_RST_INT_CTRL = 32'h0000_0000;
    localparam logic [7:0]  CRIF_RST_IRQ_MASK = 8'hcf;
    localparam logic [4:0]  CRIF_RST_ENABLE   = 5'h00;

    // ------------------------------------------------------------
    // Sources: 0 rc32, 1 slow crystal, 2 rc16, 3 fast crystal,
    // 4 digital pll, 5 crystal stuck
    // ------------------------------------------------------------
    localparam int unsigned CRIF_NSRC   = 6;
    localparam int unsigned CRIF_NEN    = 5;
    localparam int unsigned CRIF_STUCK  = 5;
    localparam int unsigned CRIF_LANE_W = 8;
    localparam int unsigned CRIF_FLAG_POS  [CRIF_NSRC] = '{0, 1, 2, 3, 6, 7};
    localparam int unsigned CRIF_ENABLE_POS[CRIF_NEN]  = '{8, 9, 10, 11, 14};
    localparam int unsigned CRIF_CLEAR_POS [CRIF_NSRC] =
        '{16, 17, 18, 19, 22, 23};

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] CRIF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CRIF_RESP_SLVERR = 2'h2;

endpackage : crif_pkg

// >>> hw/crif_flag_cell.sv
`timescale 1ns/1ps
module crif_flag_cell (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ready,
    input  wire logic enable,
    input  wire logic clear,
    output logic      flag
);
    import crif_pkg::*;

    typedef struct packed {
        logic prev;
        logic flag;
    } crif_cell_type;

    crif_cell_type state_r;
    crif_cell_type state_nxt;
    logic          set_evt;

    always_comb begin
        state_nxt      = state_r;
        state_nxt.prev = ready;
        set_evt        = ready & ~state_r.prev & enable;
        state_nxt.flag = set_evt | (state_r.flag & ~clear);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flag = state_r.flag;

endmodule : crif_flag_cell

// >>> tb/crif_top_tb.sv
`timescale 1ns/1ps
module crif_top_tb;
    import crif_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [5:0]  ready_r;
    logic        clock_irq;
    int          mismatches;
    int          n_tests;
    logic [31:0] en_all;

    crif_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rc32_ready(ready_r[0]), .slow_crystal_ready(ready_r[1]),
        .rc16_ready(ready_r[2]), .fast_crystal_ready(ready_r[3]),
        .digital_pll_ready(ready_r[4]),
        .crystal_stuck_detect(ready_r[5]),
        .clock_irq(clock_irq)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_irq(input logic exp);
        repeat (2) @(posedge aclk);
        #1;
        n_tests++;
        if (clock_irq !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, clock_irq, exp);
        end
    endtask : check_irq

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check_word({30'h0, s_axi_bresp}, {30'h0, resp});
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                            input logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        check_word(s_axi_rdata, exp);
        check_word({30'h0, s_axi_rresp}, {30'h0, resp});
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        n_tests = 0;
        en_all = 32'h0000_4f00;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        ready_r = 6'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h0c, 32'h0000_0000, CRIF_RESP_OKAY);
        axi_read(8'h40, 32'h0000_00cf, CRIF_RESP_OKAY);
        check_irq(1'b0); // idle
        $display("test reset_values done");
        // Flag bits written high are ignored, clear bits read zero
        axi_write(8'h0c, 32'h0000_4fcf, CRIF_RESP_OKAY);
        axi_read(8'h0c, en_all, CRIF_RESP_OKAY);
        $display("test enable_rw done");
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            ready_r[i] <= 1'b1;
            repeat (3) @(posedge aclk);
            axi_read(8'h0c, en_all | (32'h1 << CRIF_FLAG_POS[i]), 2'h0);
            check_irq(1'b1); // raised
            axi_write(8'h0c, en_all | (32'h1 << CRIF_CLEAR_POS[i]), 2'h0);
            axi_read(8'h0c, en_all, CRIF_RESP_OKAY); // clear reads 0
            check_irq(1'b0); // dropped
            @(posedge aclk);
            ready_r[i] <= 1'b0;
        end
        $display("test each_source done");
        axi_write(8'h0c, 32'h0000_0000, CRIF_RESP_OKAY); // all enables off
        @(posedge aclk);
        ready_r <= 6'h3f;
        repeat (3) @(posedge aclk);
        axi_read(8'h0c, 32'h0000_0080, CRIF_RESP_OKAY); // blocked
        axi_write(8'h0c, 32'h0000_0000, CRIF_RESP_OKAY);
        axi_read(8'h0c, 32'h0000_0080, CRIF_RESP_OKAY); // zero keeps
        axi_write(8'h0c, 32'h0080_0000, CRIF_RESP_OKAY); // clear
        axi_read(8'h0c, 32'h0000_0000, CRIF_RESP_OKAY); // cleared
        ready_r <= 6'h00;
        $display("test enables_off done");
        axi_write(8'h40, 32'h0000_0000, CRIF_RESP_OKAY);
        axi_write(8'h0c, en_all, CRIF_RESP_OKAY);
        @(posedge aclk);
        ready_r[0] <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_read(8'h0c, 32'h0000_4f01, CRIF_RESP_OKAY); // set
        check_irq(1'b0); // masked
        axi_write(8'h40, 32'h0000_00cf, CRIF_RESP_OKAY);
        check_irq(1'b1); // unmasked
        axi_read(8'h40, 32'h0000_00cf, CRIF_RESP_OKAY);
        axi_write(8'h0c, 32'h0001_4f00, CRIF_RESP_OKAY); // clear
        check_irq(1'b0); // cleared
        @(posedge aclk);
        ready_r[0] <= 1'b0;
        $display("test irq_mask done");
        // Ready rises at the write's handshake edge: set meets clear
        fork
            axi_write(8'h0c, 32'h0001_4f00, CRIF_RESP_OKAY);
            begin
                repeat (2) @(posedge aclk);
                ready_r[0] <= 1'b1;
            end
        join
        axi_read(8'h0c, 32'h0000_4f01, CRIF_RESP_OKAY); // set wins
        axi_write(8'h0c, 32'h0001_4f00, CRIF_RESP_OKAY); // clear
        axi_read(8'h0c, en_all, CRIF_RESP_OKAY); // cleared
        ready_r[0] <= 1'b0;
        $display("test set_wins done");
        axi_write(8'h20, 32'h0000_0000, CRIF_RESP_SLVERR);
        axi_read(8'h20, 32'h0000_0000, CRIF_RESP_SLVERR);
        axi_read(8'h0c, en_all, CRIF_RESP_OKAY); // unchanged
        $display("test unmapped done");
        end_of_test();
    end

endmodule : crif_top_tb
